// [hw/four_channel_pulse_counter.sv]
//----------------------------------------------------------------------
// Summary of operation
// (RQ1) Channels one and four do quadrature or single-phase; two, three single
// (RQ2) Channel one uses terminals 0,1,2; channel four uses 6,7 and index 5
// (RQ3) Quadrature mode counts up or down from the two phase inputs
// (RQ4) A leading B counts up, B leading down, one step per cycle
// (RQ5) Every count is an unsigned 16-bit value from zero to maximum
// (RQ6) Quadrature wrap past maximum or below zero sets the comparison output
// (RQ7) After quadrature wrap the count reloads from the reload word
// (RQ8) Quadrature index input loads the reload word and counting continues
// (RQ9) Quadrature software reset also loads the reload word
// (RQ10) A channel counts only while its gate bit is set
// (RQ11) Quadrature overflow and underflow flags rise in the following scan
// (RQ12) Index, overflow, underflow and hit flags last exactly one scan
// (RQ13) Compare-clear bit turns the channel's comparison output off
// (RQ14) Comparison output stays latched until compare-clear is set
// (RQ15) Index reset raises the reset flag next scan; software reset does not
// (RQ16) Program writes zero reload when index serves as encoder marker
// (RQ17) Inputs take 20 kHz on channels one and four, 5 kHz on two, three
// (RQ18) Single-phase counts up; at preset, compare output on and count zero
// (RQ19) Single-phase hit flag rises in the scan after the preset is reached
// (RQ20) Preset word at hit or reset becomes the next compare target
// (RQ21) Single-phase software reset clears the count to zero
// (RQ22) Single-phase index terminal exists on one and four, clears and flags
// (RQ23) Internal count copied to the readable word once per scan
// (RQ24) Power-up, download and system reset return counts to start value
//----------------------------------------------------------------------
`timescale 1ns/1ps
module four_channel_pulse_counter (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  term_in,
   input  wire logic        sys_reset_in,
   input  wire logic        download_pulse,
   input  wire logic        scan_tick,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic      [3:0]  cmp_out
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Count and reload words share one decode: 8 bytes per channel
   function automatic logic is_chan_reg(input logic [7:0] a);
      is_chan_reg = (a[7:5] == 3'b000) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [1:0] chan_of(input logic [7:0] a);
      chan_of = a[4:3];
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0]  term_s1_q;
   logic [7:0]  term_s2_q;
   logic        sysrst_s1_q;
   logic        sysrst_s2_q;
   logic [1:0]  idx_prev_q;
   logic [3:0]  gate_q;
   logic [3:0]  srst_q;
   logic [3:0]  cclr_q;
   logic [3:0]  mode_q;
   logic [15:0] reload_q [4];
   logic [15:0] cnt_q    [4];
   logic [15:0] cur_q    [4];
   logic [15:0] target_q [4];
   logic [3:0]  cmp_q;
   logic [3:0]  idx_pend_q;
   logic [3:0]  ovf_pend_q;
   logic [3:0]  udf_pend_q;
   logic [3:0]  idx_flag_q;
   logic [3:0]  ovf_flag_q;
   logic [3:0]  udf_flag_q;
   logic [31:0] rdata_q;
   logic [3:0]  quad;
   logic [3:0]  step_up;
   logic [3:0]  step_down;
   logic [3:0]  idx_hit;
   logic [3:0]  wrap_up;
   logic [3:0]  wrap_down;
   logic [3:0]  preset_hit;
   logic        init_cnt;
   logic [3:0]  ph_a;
   logic [3:0]  ph_b;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Two stages at 50 MHz leave ample margin over the pulse rates
   always_ff @(posedge core_clk) begin
      if (rst) begin
         term_s1_q   <= 8'h00;
         term_s2_q   <= 8'h00;
         sysrst_s1_q <= 1'b0;
         sysrst_s2_q <= 1'b0;
      end else begin
         term_s1_q   <= term_in;  // [RQ17]
         term_s2_q   <= term_s1_q;
         sysrst_s1_q <= sys_reset_in;
         sysrst_s2_q <= sysrst_s1_q;
      end
   end

   // Counts restart on download or while system reset input is on
   assign init_cnt = download_pulse | sysrst_s2_q;  // [RQ24]

   // ----------------------------------------
   // Mode and terminal routing
   // ----------------------------------------
   // Channels two and three have no quadrature option
   assign quad[0] = mode_q[pulse_counter_pkg::MODE_Q1_POS];  // [RQ1]
   assign quad[1] = 1'b0;  // [RQ1]
   assign quad[2] = 1'b0;  // [RQ1]
   assign quad[3] = mode_q[pulse_counter_pkg::MODE_Q4_POS];  // [RQ1]

   // Single-phase pulses ride on the phase B lane
   always_comb begin
      ph_a = 4'h0;
      ph_b = 4'h0;
      ph_a[0] = term_s2_q[pulse_counter_pkg::T_CH1_A];  // [RQ2]
      ph_b[0] = term_s2_q[pulse_counter_pkg::T_CH1_B];  // [RQ2]
      ph_b[1] = term_s2_q[pulse_counter_pkg::T_CH2_P];
      ph_b[2] = term_s2_q[pulse_counter_pkg::T_CH3_P];
      ph_a[3] = term_s2_q[pulse_counter_pkg::T_CH4_A];  // [RQ2]
      ph_b[3] = term_s2_q[pulse_counter_pkg::T_CH4_B];  // [RQ2]
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_dec
         pulse_step_decoder u_dec (
            .core_clk  (core_clk),
            .rst       (rst),
            .quad      (quad[g]),
            .phase_a   (ph_a[g]),
            .phase_b   (ph_b[g]),
            .step_up   (step_up[g]),
            .step_down (step_down[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Index terminals
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx_prev_q <= 2'b00;
      end else begin
         idx_prev_q[0] <= term_s2_q[pulse_counter_pkg::T_CH1_IDX];
         idx_prev_q[1] <= term_s2_q[pulse_counter_pkg::T_CH4_IDX];
      end
   end

   // Only channels one and four own an index terminal
   always_comb begin
      idx_hit = 4'h0;
      idx_hit[0] = mode_q[pulse_counter_pkg::MODE_IX1_POS]
                 & term_s2_q[pulse_counter_pkg::T_CH1_IDX]
                 & ~idx_prev_q[0];  // [RQ2] [RQ22]
      idx_hit[3] = mode_q[pulse_counter_pkg::MODE_IX4_POS]
                 & term_s2_q[pulse_counter_pkg::T_CH4_IDX]
                 & ~idx_prev_q[1];  // [RQ2] [RQ22]
   end

   // ----------------------------------------
   // Count events
   // ----------------------------------------
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         wrap_up[c]    = quad[c] & gate_q[c] & step_up[c]
                       & (cnt_q[c] == pulse_counter_pkg::CNT_MAX);  // [RQ6]
         wrap_down[c]  = quad[c] & gate_q[c] & step_down[c]
                       & (cnt_q[c] == pulse_counter_pkg::CNT_ZERO);  // [RQ6]
         preset_hit[c] = ~quad[c] & gate_q[c] & step_up[c]
                       & ((cnt_q[c] + 16'h0001) == target_q[c]);  // [RQ18]
      end
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   // Resets win over a count step landing in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < 4; c++) begin
            cnt_q[c]    <= pulse_counter_pkg::RELOAD_RST;  // [RQ24]
            target_q[c] <= pulse_counter_pkg::RELOAD_RST;
         end
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (init_cnt) begin
               cnt_q[c]    <= quad[c] ? reload_q[c]
                                      : pulse_counter_pkg::CNT_ZERO;  // [RQ24]
               target_q[c] <= reload_q[c];
            end else if (srst_q[c] | idx_hit[c]) begin
               if (quad[c]) begin
                  cnt_q[c] <= reload_q[c];  // [RQ8] [RQ9]
               end else begin
                  cnt_q[c]    <= pulse_counter_pkg::CNT_ZERO;  // [RQ21] [RQ22]
                  target_q[c] <= reload_q[c];  // [RQ20]
               end
            end else if (wrap_up[c] | wrap_down[c]) begin
               cnt_q[c] <= reload_q[c];  // [RQ7]
            end else if (preset_hit[c]) begin
               cnt_q[c]    <= pulse_counter_pkg::CNT_ZERO;  // [RQ18]
               target_q[c] <= reload_q[c];  // [RQ20]
            end else if (gate_q[c] & step_up[c]) begin
               cnt_q[c] <= cnt_q[c] + 16'h0001;  // [RQ5] [RQ10]
            end else if (gate_q[c] & step_down[c]) begin
               cnt_q[c] <= cnt_q[c] - 16'h0001;  // [RQ5] [RQ10]
            end
         end
      end
   end

   // ----------------------------------------
   // Comparison outputs
   // ----------------------------------------
   // A new event in the clear cycle keeps the output on
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmp_q <= 4'h0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (wrap_up[c] | wrap_down[c] | preset_hit[c]) begin
               cmp_q[c] <= 1'b1;  // [RQ6] [RQ14] [RQ18]
            end else if (cclr_q[c]) begin
               cmp_q[c] <= 1'b0;  // [RQ13]
            end
         end
      end
   end

   assign cmp_out = cmp_q;

   // ----------------------------------------
   // Scan-paced status
   // ----------------------------------------
   // Events wait for the next scan boundary, then show for one scan
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx_pend_q <= 4'h0;
         ovf_pend_q <= 4'h0;
         udf_pend_q <= 4'h0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (idx_hit[c] & ~srst_q[c] & ~init_cnt) begin
               idx_pend_q[c] <= 1'b1;  // [RQ15] [RQ22]
            end else if (scan_tick) begin
               idx_pend_q[c] <= 1'b0;
            end
            if (wrap_up[c] | preset_hit[c]) begin
               ovf_pend_q[c] <= 1'b1;  // [RQ11] [RQ19]
            end else if (scan_tick) begin
               ovf_pend_q[c] <= 1'b0;
            end
            if (wrap_down[c]) begin
               udf_pend_q[c] <= 1'b1;  // [RQ11]
            end else if (scan_tick) begin
               udf_pend_q[c] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx_flag_q <= 4'h0;
         ovf_flag_q <= 4'h0;
         udf_flag_q <= 4'h0;
      end else if (scan_tick) begin
         idx_flag_q <= idx_pend_q;  // [RQ12] [RQ15]
         ovf_flag_q <= ovf_pend_q;  // [RQ11] [RQ12] [RQ19]
         udf_flag_q <= udf_pend_q;  // [RQ11] [RQ12]
      end
   end

   // Readable count lags the live count by up to one scan
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < 4; c++) begin
            cur_q[c] <= pulse_counter_pkg::RELOAD_RST;
         end
      end else if (scan_tick) begin
         for (int c = 0; c < 4; c++) begin
            cur_q[c] <= cnt_q[c];  // [RQ23]
         end
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Reload of zero is the program's duty for marker use [RQ16]
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < 4; c++) begin
            reload_q[c] <= pulse_counter_pkg::RELOAD_RST;
         end
      end else if (reg_wr & is_chan_reg(reg_addr) & reg_addr[2]) begin
         reload_q[chan_of(reg_addr)] <= reg_wdata[15:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         gate_q <= 4'h0;
         mode_q <= 4'h0;
      end else if (reg_wr) begin
         if (reg_addr == pulse_counter_pkg::CTRL_OFS) begin
            gate_q <=
               reg_wdata[pulse_counter_pkg::CTRL_GATE_POS +: 4];  // [RQ10]
         end
         if (reg_addr == pulse_counter_pkg::MODE_OFS) begin
            mode_q <= reg_wdata[3:0];  // [RQ1]
         end
      end
   end

   // Software reset and compare-clear are one-cycle strobes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         srst_q <= 4'h0;
         cclr_q <= 4'h0;
      end else if (reg_wr && reg_addr == pulse_counter_pkg::CTRL_OFS) begin
         srst_q <= reg_wdata[pulse_counter_pkg::CTRL_SRST_POS +: 4];  // [RQ9]
         cclr_q <= reg_wdata[pulse_counter_pkg::CTRL_CCLR_POS +: 4];  // [RQ13]
      end else begin
         srst_q <= 4'h0;
         cclr_q <= 4'h0;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_q <= 32'h0000_0000;
         if (is_chan_reg(reg_addr)) begin
            if (reg_addr[2]) begin
               rdata_q[15:0] <= reload_q[chan_of(reg_addr)];
            end else begin
               rdata_q[15:0] <= cur_q[chan_of(reg_addr)];  // [RQ23]
            end
         end else if (reg_addr == pulse_counter_pkg::CTRL_OFS) begin
            rdata_q[pulse_counter_pkg::CTRL_GATE_POS +: 4] <= gate_q;
         end else if (reg_addr == pulse_counter_pkg::MODE_OFS) begin
            rdata_q[3:0] <= mode_q;
         end else if (reg_addr == pulse_counter_pkg::STATUS_OFS) begin
            rdata_q[pulse_counter_pkg::ST_IDX_POS +: 4] <= idx_flag_q;
            rdata_q[pulse_counter_pkg::ST_OVF_POS +: 4] <= ovf_flag_q;
            rdata_q[pulse_counter_pkg::ST_UDF_POS +: 4] <= udf_flag_q;
            rdata_q[pulse_counter_pkg::ST_CMP_POS +: 4] <= cmp_q;
         end
      end
   end

   assign reg_rdata = rdata_q;

endmodule

// [hw/pulse_counter_pkg.sv]
package pulse_counter_pkg;

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int NUM_CH      = 4;
   localparam int CNT_W       = 16;
   localparam int NUM_TERM    = 8;
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CH1_CUR_OFS    = 8'h00;
   localparam logic [7:0] CH1_RELOAD_OFS = 8'h04;
   localparam logic [7:0] CH2_CUR_OFS    = 8'h08;
   localparam logic [7:0] CH2_PRESET_OFS = 8'h0C;
   localparam logic [7:0] CH3_CUR_OFS    = 8'h10;
   localparam logic [7:0] CH3_PRESET_OFS = 8'h14;
   localparam logic [7:0] CH4_CUR_OFS    = 8'h18;
   localparam logic [7:0] CH4_RELOAD_OFS = 8'h1C;
   localparam logic [7:0] CTRL_OFS       = 8'h20;
   localparam logic [7:0] MODE_OFS       = 8'h24;
   localparam logic [7:0] STATUS_OFS     = 8'h28;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_GATE_POS  = 0;
   localparam int CTRL_SRST_POS  = 4;
   localparam int CTRL_CCLR_POS  = 8;
   localparam int MODE_Q1_POS    = 0;
   localparam int MODE_Q4_POS    = 1;
   localparam int MODE_IX1_POS   = 2;
   localparam int MODE_IX4_POS   = 3;
   localparam int ST_IDX_POS     = 0;
   localparam int ST_OVF_POS     = 4;
   localparam int ST_UDF_POS     = 8;
   localparam int ST_CMP_POS     = 12;

   // ----------------------------------------
   // Terminal assignment
   // ----------------------------------------
   localparam int T_CH1_A   = 0;
   localparam int T_CH1_B   = 1;
   localparam int T_CH1_IDX = 2;
   localparam int T_CH2_P   = 3;
   localparam int T_CH3_P   = 4;
   localparam int T_CH4_IDX = 5;
   localparam int T_CH4_A   = 6;
   localparam int T_CH4_B   = 7;

   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [15:0] RELOAD_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO   = 16'h0000;
   localparam int QUAD_MAX_HZ   = 20000;
   localparam int SINGLE_MAX_HZ = 5000;

endpackage

// [hw/pulse_step_decoder.sv]
`timescale 1ns/1ps
module pulse_step_decoder (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic quad,
   input  wire logic phase_a,
   input  wire logic phase_b,
   output logic      step_up,
   output logic      step_down
);

   logic a_q;
   logic b_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end else begin
         a_q <= phase_a;
         b_q <= phase_b;
      end
   end

   // ----------------------------------------
   // Step decode
   // ----------------------------------------
   // One step per full cycle: A edges sampled only while B is low
   always_comb begin
      step_up   = 1'b0;
      step_down = 1'b0;
      if (quad) begin
         step_up   = phase_a & ~a_q & ~phase_b;  // [RQ3] [RQ4]
         step_down = ~phase_a & a_q & ~phase_b;  // [RQ3] [RQ4]
      end else begin
         step_up   = phase_b & ~b_q;  // [RQ18]
      end
   end

endmodule

// [verif/pulse_counter_props.sv]
`timescale 1ns/1ps
module pulse_counter_props (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [3:0]  cmp_out
);
   // ----------------------------------------
   // Clear mask, delayed to the edge it acts
   // ----------------------------------------
   logic       ctl_wr;
   logic [3:0] clr1_q;
   logic [3:0] clr2_q;
   assign ctl_wr = reg_wr && reg_addr == pulse_counter_pkg::CTRL_OFS;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clr1_q <= 4'h0;
         clr2_q <= 4'h0;
      end else begin
         clr1_q <= ctl_wr ? reg_wdata[11:8] : 4'h0;
         clr2_q <= clr1_q;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_clear_one;
      ctl_wr && reg_wdata[8];
   endsequence
   sequence s_one_off;
      ##2 !cmp_out[0];
   endsequence
   a_clear_turns_off: assert property (s_clear_one |-> s_one_off)
      else $error("compare output one still on after clear");
   a_cmp_stays_latched: assert property (
      ($past(cmp_out) & ~cmp_out & ~clr2_q) == 4'h0)
      else $error("compare output dropped without clear");
   a_rdata_holds: assert property (
      !$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_status_cmp_bits: assert property (
      reg_rd && reg_addr == pulse_counter_pkg::STATUS_OFS
      |=> reg_rdata[15:12] == $past(cmp_out))
      else $error("status compare bits differ from outputs");
   a_upper_half_zero: assert property (
      reg_rd |=> reg_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr > pulse_counter_pkg::STATUS_OFS
      |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_strobes_read_zero: assert property (
      reg_rd && reg_addr == pulse_counter_pkg::CTRL_OFS
      |=> reg_rdata[11:4] == 8'h00)
      else $error("control strobe bits read back");
   a_init_outputs_zero: assert property (
      $fell(rst) |-> reg_rdata == 32'h0000_0000 && cmp_out == 4'h0)
      else $error("outputs not cleared by reset");
endmodule
bind four_channel_pulse_counter pulse_counter_props pulse_counter_props_i (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .cmp_out(cmp_out));

// [verif/pulse_source_model.sv]
`timescale 1ns/1ps
module pulse_source_model (
   input  wire logic       core_clk,
   output logic      [7:0] term
);
   // ----------------------------------------
   // Encoder and pulse terminals, push-pull
   // ----------------------------------------
   initial term = 8'h00;
   // Any gap of 3 or more is seen cleanly past the sync stages
   task automatic set_pin(int pin, bit val, int gap);
      @(posedge core_clk);
      term[pin] <= val;
      repeat (gap) @(posedge core_clk);
   endtask
   task automatic pulse(int pin, int gap);
      set_pin(pin, 1'b1, gap);
      set_pin(pin, 1'b0, gap);
   endtask
   task automatic quad_cycle(int c, bit up, int gap);
      int a;
      int b;
      a = c == 0 ? pulse_counter_pkg::T_CH1_A : pulse_counter_pkg::T_CH4_A;
      b = c == 0 ? pulse_counter_pkg::T_CH1_B : pulse_counter_pkg::T_CH4_B;
      set_pin(up ? a : b, 1'b1, gap);
      set_pin(up ? b : a, 1'b1, gap);
      set_pin(up ? a : b, 1'b0, gap);
      set_pin(up ? b : a, 1'b0, gap);
   endtask
endmodule

// [verif/four_channel_pulse_counter_tb_top.sv]
`timescale 1ns/1ps
module four_channel_pulse_counter_tb_top;
   // ----------------------------------------
   // Bench signals and reference model
   // ----------------------------------------
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        sys_reset_in = 1'b0;
   logic        download_pulse = 1'b0;
   logic        scan_tick = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0]  cmp_out;
   logic [7:0]  term_in;
   logic [31:0] seed = 32'h0000_7bac;
   logic [31:0] v;
   logic [3:0]  gate = 4'h0, mode = 4'h0, cmp = 4'h0;
   logic [3:0]  p_idx = 4'h0, p_ovf = 4'h0, p_udf = 4'h0;
   logic [3:0]  s_idx = 4'h0, s_ovf = 4'h0, s_udf = 4'h0;
   int          cnt[4] = '{default: 0};
   int          rel[4] = '{default: 0};
   int          tgt[4] = '{default: 0};
   int          lane[4] = '{1, 3, 4, 7};
   int          errors = 0;
   int          checks_done = 0;
   always #10 core_clk = ~core_clk;
   four_channel_pulse_counter four_channel_pulse_counter_i (
      .core_clk(core_clk), .rst(rst), .term_in(term_in),
      .sys_reset_in(sys_reset_in), .download_pulse(download_pulse),
      .scan_tick(scan_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cmp_out(cmp_out));
   pulse_source_model src_i (.core_clk(core_clk), .term(term_in));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic bit quad(int c);
      return (c == 0 && mode[0]) || (c == 3 && mode[1]);
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      v = reg_rdata;
   endtask
   task automatic m_load(logic [3:0] m);
      for (int c = 0; c < 4; c++)
         if (m[c]) begin
            cnt[c] = quad(c) ? rel[c] : 0;
            tgt[c] = rel[c];
         end
   endtask
   task automatic m_step(int c, bit up);
      if (!gate[c])
         return;
      if (!quad(c) && cnt[c] + 1 == tgt[c]) begin
         cnt[c] = 0;
         tgt[c] = rel[c];
         cmp[c] = 1'b1;
         p_ovf[c] = 1'b1;
      end else if (!quad(c))
         cnt[c] = (cnt[c] + 1) % 65536;
      else if (up ? cnt[c] == 65535 : cnt[c] == 0) begin
         cnt[c] = rel[c];
         cmp[c] = 1'b1;
         p_ovf[c] = p_ovf[c] | up;
         p_udf[c] = p_udf[c] | !up;
      end else
         cnt[c] = up ? cnt[c] + 1 : cnt[c] - 1;
   endtask
   task automatic set_rel(int c, int x);
      wr(8'(c * 8 + 4), 32'(x));
      rel[c] = x;
      rd(8'(c * 8 + 4));
      chk(v, 32'(x), "preset word");
   endtask
   task automatic set_mode(logic [3:0] m);
      wr(pulse_counter_pkg::MODE_OFS, {28'h000_0000, m});
      mode = m;
   endtask
   task automatic ctrl(logic [3:0] g, logic [3:0] s, logic [3:0] c);
      wr(pulse_counter_pkg::CTRL_OFS, {20'h0_0000, c, s, g});
      gate = g;
      cmp = cmp & ~c;
      m_load(s);
      rd(pulse_counter_pkg::CTRL_OFS);
      chk(v, {28'h000_0000, g}, "control readback");
   endtask
   task automatic move(int c, bit up);
      int g;
      g = 3 + int'(rnd() % 4);
      if (quad(c))
         src_i.quad_cycle(c, up, g);
      else
         src_i.pulse(lane[c], g);
      m_step(c, up);
   endtask
   task automatic index(int c);
      src_i.pulse(c == 0 ? 2 : 5, 4);
      m_load(c == 0 ? 4'h1 : 4'h8);
      p_idx[c] = 1'b1;
   endtask
   task automatic tick();
      scan_tick <= 1'b1;
      @(posedge core_clk);
      scan_tick <= 1'b0;
      @(posedge core_clk);
      {s_idx, s_ovf, s_udf} = {p_idx, p_ovf, p_udf};
      {p_idx, p_ovf, p_udf} = 12'h000;
   endtask
   task automatic check_all();
      tick();
      for (int c = 0; c < 4; c++) begin
         rd(8'(c * 8));
         chk(v, 32'(cnt[c]), "current count");
      end
      rd(pulse_counter_pkg::STATUS_OFS);
      chk(v, {16'h0000, cmp, s_udf, s_ovf, s_idx}, "status");
      chk({28'h000_0000, cmp_out}, {28'h000_0000, cmp}, "compare pins");
   endtask
   task automatic done(string n);
      $display("test %s finished", n);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      for (int a = 0; a <= 48; a += 4) begin
         rd(8'(a));
         chk(v, 32'h0000_0000, "reset value");
      end
      wr(pulse_counter_pkg::CH1_CUR_OFS, rnd() & 32'h0000_ffff);
      rd(pulse_counter_pkg::CH1_CUR_OFS);
      chk(v, 32'h0000_0000, "read-only count");
      done("reset");
      for (int c = 0; c < 4; c++)
         set_rel(c, 2 + int'(rnd() % 4));
      ctrl(4'hf, 4'hf, 4'h0);
      for (int c = 0; c < 4; c++) begin
         set_rel(c, 7);
         repeat (tgt[c] + 1) move(c, 1'b1);
      end
      check_all();
      ctrl(4'h0, 4'h0, 4'h0);
      for (int c = 0; c < 4; c++)
         move(c, 1'b1);
      check_all();
      ctrl(4'hf, 4'h0, 4'hf);
      set_mode(4'hc);
      index(0);
      index(3);
      check_all();
      done("single phase");
      set_mode(4'hf);
      set_rel(0, 16'hfffd);
      set_rel(3, 2);
      ctrl(4'hf, 4'h9, 4'h0);
      repeat (3) move(0, 1'b1);
      repeat (3) move(3, 1'b0);
      check_all();
      set_rel(0, 0);
      index(0);
      move(0, 1'b0);
      check_all();
      repeat (40) move(int'(rnd() % 4), rnd() % 2 == 1);
      check_all();
      done("quadrature");
      ctrl(4'hf, 4'h0, 4'hf);
      download_pulse <= 1'b1;
      @(posedge core_clk);
      download_pulse <= 1'b0;
      m_load(4'hf);
      repeat (4) @(posedge core_clk);
      check_all();
      ctrl(4'hf, 4'h0, 4'h0);
      move(0, 1'b1);
      move(1, 1'b1);
      tick();
      sys_reset_in <= 1'b1;
      repeat (6) @(posedge core_clk);
      sys_reset_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      m_load(4'hf);
      check_all();
      done("restart");
      final_report();
   end
   // Generous span: the sequence above needs well under a tenth of it
   initial begin
      repeat (50000) @(posedge core_clk);
      errors++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      final_report();
   end
endmodule
